// *** hdl/sfw_window.sv ***
// bus-facing data window of a serial controller's transmit/receive fifos
// assumes an apb-style slave port on the peripheral clock, the shift
// engine on the far side of the fifo ports, and enable from a control reg
//
// Contract
// - data field is 16 bits, bits 15:0 of each window word
// - each window read with the receive fifo non-empty pops oldest entry onto read data
// - write pushes data into transmit fifo only while enable is 1
// - enable at 0 holds both fifos empty
// - thirty-six consecutive word addresses alias the same window
// - no fifo entry is reachable at its own address
// - received words read right-justified, unused upper bits zero
// - bits 31:16 are reserved, read as zero
`timescale 1ns/100ps
`default_nettype none
`include "sfw_regs.svh"
module sfw_window
  import sfw_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic CONTROLLER_ENABLE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic RX_VALID_I,
  input wire logic [15:0] RX_DATA_I,
  output logic RX_READY_O,
  output logic TX_VALID_O,
  output logic [15:0] TX_DATA_O,
  input wire logic TX_READY_I,
  output logic [3:0] TX_LEVEL_O,
  output logic [3:0] RX_LEVEL_O
);
  sfw_apb_state_t state_reg;
  sfw_apb_state_t state_next;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic rx_ready_reg;
  logic tx_valid_reg;
  logic [15:0] tx_data_reg;
  logic [3:0] tx_level_reg;
  logic [3:0] rx_level_reg;
  logic enable_reg;

  sfw_beat_t txf_in;
  sfw_beat_t txf_out;
  sfw_beat_t rxf_in;
  sfw_beat_t rxf_out;
  logic txf_wr_ready;
  logic rxf_wr_ready;
  logic [3:0] txf_level;
  logic [3:0] rxf_level;

  // decode: every word offset in the aliased span maps onto one window
  wire logic [7:0] word_off = PADDR_I - `SFW_WIN_BASE;
  wire logic in_window = (PADDR_I >= `SFW_WIN_BASE) &&
    ({2'h0, word_off[7:2]} < `SFW_WIN_WORDS) && (PADDR_I[1:0] == 2'h0);
  // low address bits never pick an entry; only push and pop reach data
  wire logic access = PSEL_I && PENABLE_I && (state_reg == SFW_SETUP);
  wire logic wr_hit = access && PWRITE_I && in_window;
  wire logic rd_hit = access && !PWRITE_I && in_window;
  wire logic bad_addr = access && !in_window;
  // a write while disabled, or into a full fifo, is dropped with an error
  wire logic wr_drop = wr_hit && !(enable_reg && txf_wr_ready);
  wire logic rd_pop = rd_hit && rxf_out.valid;
  // flush while disabled; registered enable keeps flush glitch-free
  wire logic flush = !enable_reg;
  // only bits 15:0 are taken; upper write bits are ignored
  wire sfw_word_t wr_word = PWDATA_I[`SFW_DATA_MSB:0];
  // the master right-justifies short frames, so no shifting here
  wire sfw_word_t rd_word = rxf_out.data;
  wire logic [31:0] rd_value = rd_pop ?
    {`SFW_RSVD_ZERO, rd_word} : `SFW_RESET_VAL;

  assign txf_in.valid = wr_hit && enable_reg;
  assign txf_in.data = wr_word;
  assign rxf_in.valid = RX_VALID_I;
  assign rxf_in.data = RX_DATA_I;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SFW_IDLE: begin
        if (PSEL_I && !PENABLE_I)
          state_next = SFW_SETUP;
      end
      SFW_SETUP: begin
        if (PSEL_I && PENABLE_I)
          state_next = SFW_ACCESS;
        else if (!PSEL_I)
          state_next = SFW_IDLE;
      end
      SFW_ACCESS: begin
        state_next = (PSEL_I && !PENABLE_I) ? SFW_SETUP : SFW_IDLE;
      end
      default: begin
        state_next = SFW_IDLE;
      end
    endcase
  end

  // pop strobe is one cycle per access, so one read pops at most once
  sfw_fifo u_tx_fifo (
    .clk_i(REF_CLK_I),
    .arst_n_i(ARST_N_I),
    .flush_i(flush),
    .wr_i(txf_in),
    .wr_ready_o(txf_wr_ready),
    .rd_ready_i(TX_READY_I && tx_valid_reg == 1'b0),
    .rd_o(txf_out),
    .level_o(txf_level)
  );

  sfw_fifo u_rx_fifo (
    .clk_i(REF_CLK_I),
    .arst_n_i(ARST_N_I),
    .flush_i(flush),
    .wr_i(rxf_in),
    .wr_ready_o(rxf_wr_ready),
    .rd_ready_i(rd_pop),
    .rd_o(rxf_out),
    .level_o(rxf_level)
  );

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg <= SFW_IDLE;
      enable_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      enable_reg <= CONTROLLER_ENABLE_I;
    end
  end

  // bus answer: two access phase cycles (one wait state), ready and data from flops
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      prdata_reg <= `SFW_RESET_VAL;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= rd_value;
      pready_reg <= access;
      pslverr_reg <= bad_addr || wr_drop;
    end
  end

  // tx output stage: a one-word output register that presents each word for one cycle toward the shifter
  wire logic tx_take = !tx_valid_reg && txf_out.valid && TX_READY_I;
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tx_valid_reg <= 1'b0;
      tx_data_reg <= '0;
    end else if (flush) begin
      tx_valid_reg <= 1'b0;
    end else if (tx_take) begin
      tx_valid_reg <= 1'b1;
      tx_data_reg <= txf_out.data;
    end else begin
      tx_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rx_ready_reg <= 1'b0;
      tx_level_reg <= '0;
      rx_level_reg <= '0;
    end else begin
      // registered ready lags a cycle; the source must see it before sending
      rx_ready_reg <= rxf_wr_ready && (rxf_level < 4'h7);
      tx_level_reg <= txf_level;
      rx_level_reg <= rxf_level;
    end
  end

  assign PRDATA_O = prdata_reg;
  assign PREADY_O = pready_reg;
  assign PSLVERR_O = pslverr_reg;
  assign RX_READY_O = rx_ready_reg;
  assign TX_VALID_O = tx_valid_reg;
  assign TX_DATA_O = tx_data_reg;
  assign TX_LEVEL_O = tx_level_reg;
  assign RX_LEVEL_O = rx_level_reg;
endmodule
`default_nettype wire

// *** hdl/sfw_regs.svh ***
// offsets, field positions, reset values and depth constants for the
// serial fifo data window; included by the package-using design files
`ifndef SFW_REGS_SVH
`define SFW_REGS_SVH
// window base: first of the thirty-six aliased word locations
`define SFW_WIN_BASE 8'h60
`define SFW_WIN_WORDS 8'h24
`define SFW_ALIAS_ELEVEN 8'h8C
`define SFW_ALIAS_TWELVE 8'h90
`define SFW_ALIAS_THIRTEEN 8'h94
`define SFW_ALIAS_FOURTEEN 8'h98
`define SFW_DATA_MSB 15
`define SFW_DATA_W 16
`define SFW_RSVD_ZERO 16'h0000
`define SFW_RESET_VAL 32'h0000_0000
`define SFW_FIFO_DEPTH 8
`define SFW_PTR_W 3
`define SFW_CNT_W 4
`endif

// *** hdl/sfw_pkg.sv ***
// types shared by the serial fifo data window files
// assumes sfw_regs.svh sits beside it on the include path
`include "sfw_regs.svh"
package sfw_pkg;
  typedef logic [`SFW_DATA_W-1:0] sfw_word_t;
  typedef struct packed {
    logic valid;
    sfw_word_t data;
  } sfw_beat_t;
  typedef enum logic [2:0] {
    SFW_IDLE = 3'b001,
    SFW_SETUP = 3'b010,
    SFW_ACCESS = 3'b100
  } sfw_apb_state_t;
endpackage

// *** hdl/sfw_fifo.sv ***
// flip-flop fifo used for both directions of the data window
// assumes a single clock; flush empties it synchronously
`timescale 1ns/100ps
`default_nettype none
`include "sfw_regs.svh"
module sfw_fifo
  import sfw_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic flush_i,
  input wire sfw_beat_t wr_i,
  output logic wr_ready_o,
  input wire logic rd_ready_i,
  output sfw_beat_t rd_o,
  output logic [`SFW_CNT_W-1:0] level_o
);
  logic [`SFW_DATA_W-1:0] mem_reg [`SFW_FIFO_DEPTH];
  logic [`SFW_PTR_W-1:0] wptr_reg;
  logic [`SFW_PTR_W-1:0] rptr_reg;
  logic [`SFW_CNT_W-1:0] cnt_reg;
  wire logic full = (cnt_reg == `SFW_CNT_W'(`SFW_FIFO_DEPTH));
  wire logic empty = (cnt_reg == '0);
  wire logic push = wr_i.valid && !full && !flush_i;
  wire logic pop = rd_ready_i && !empty && !flush_i;

  assign wr_ready_o = !full && !flush_i;
  assign rd_o.valid = !empty;
  assign rd_o.data = mem_reg[rptr_reg];
  assign level_o = cnt_reg;

  genvar g;
  generate
    for (g = 0; g < `SFW_FIFO_DEPTH; g++) begin : g_ent
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
          mem_reg[g] <= '0;
        else if (push && wptr_reg == `SFW_PTR_W'(g))
          mem_reg[g] <= wr_i.data;
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else if (flush_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push)
        wptr_reg <= wptr_reg + 1'b1;
      if (pop)
        rptr_reg <= rptr_reg + 1'b1;
      cnt_reg <= cnt_reg + {3'b000, push} - {3'b000, pop};
    end
  end
endmodule
`default_nettype wire

// *** tb/sfw_window_checker.sv ***
// port assertions for the fifo data window
// assumes it is bound onto sfw_window
`timescale 1ns/100ps
`default_nettype none
module sfw_window_checker (
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic CONTROLLER_ENABLE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic TX_VALID_O,
  input wire logic [3:0] TX_LEVEL_O,
  input wire logic [3:0] RX_LEVEL_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  wire acc = PSEL_I && PENABLE_I && !PREADY_O;
  rsvd_zero_a: assert property (
    PRDATA_O[31:16] == 16'h0000) else $error("upper bits set");
  ready_lat_a: assert property (
    acc && $past(PSEL_I && !PENABLE_I) |=> PREADY_O) else $error("no ready");
  ready_once_a: assert property (
    PREADY_O |=> !PREADY_O) else $error("ready too long");
  idle_zero_a: assert property (
    !PREADY_O |-> PRDATA_O == 32'h0) else $error("stray read data");
  err_paired_a: assert property (
    PSLVERR_O |-> PREADY_O) else $error("lone error");
  drop_write_a: assert property (
    acc && PWRITE_I && !CONTROLLER_ENABLE_I && $past(!CONTROLLER_ENABLE_I)
    |=> PSLVERR_O) else $error("disabled write taken");
  flush_a: assert property (
    (!CONTROLLER_ENABLE_I) [*4] |-> TX_LEVEL_O == 4'h0 && RX_LEVEL_O == 4'h0)
    else $error("fifo not flushed");
  tx_pulse_a: assert property (
    TX_VALID_O |=> !TX_VALID_O) else $error("tx word repeated");
endmodule
bind sfw_window sfw_window_checker u_chk (.REF_CLK_I, .ARST_N_I,
  .CONTROLLER_ENABLE_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PRDATA_O,
  .PREADY_O, .PSLVERR_O, .TX_VALID_O, .TX_LEVEL_O, .RX_LEVEL_O);
`default_nettype wire

// *** tb/sfw_shifter_model.sv ***
// shift engine stand-in on the fifo side
// assumes the bench paces rx words through send_i
`timescale 1ns/100ps
`default_nettype none
module sfw_shifter_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic send_i,
  input wire logic [15:0] word_i,
  output logic rx_valid_o,
  output logic [15:0] rx_data_o,
  output logic tx_ready_o
);
  // idle data toggles so a stale word never looks valid
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_valid_o <= 1'b0;
      rx_data_o <= 16'h0000;
      tx_ready_o <= 1'b0;
    end else begin
      rx_valid_o <= send_i;
      rx_data_o <= send_i ? word_i : ~rx_data_o;
      tx_ready_o <= $urandom_range(1, 0) == 1;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_sfw_window.sv ***
// self-checking bench for the fifo data window
// assumes sfw_shifter_model on the fifo ports
`timescale 1ns/100ps
`default_nettype none
module tb_sfw_window;
  import sfw_pkg::*;
  logic clk = 0, rst_n = 0, en = 0, sel = 0, ena = 0, wr = 0, snd = 0;
  logic [7:0] adr = 0;
  logic [31:0] wd = 0, rd;
  logic rdy, err, rxv, txv, txr;
  logic [15:0] rxd, txd, sw = 0;
  logic [15:0] sent[6];
  logic rxr;
  logic [3:0] txl, rxl;
  logic [7:0] al[6] = '{8'h60, 8'h8C, 8'h90, 8'h94, 8'h98, 8'hEC};
  sfw_word_t txq[$], rdq[$];
  int errors = 0, num_checks = 0, cyc = 0;
  always #50 clk = ~clk;
  sfw_window dut (.REF_CLK_I(clk), .ARST_N_I(rst_n),
    .CONTROLLER_ENABLE_I(en), .PSEL_I(sel), .PENABLE_I(ena), .PWRITE_I(wr),
    .PADDR_I(adr), .PWDATA_I(wd), .PRDATA_O(rd), .PREADY_O(rdy),
    .PSLVERR_O(err), .RX_VALID_I(rxv), .RX_DATA_I(rxd), .RX_READY_O(rxr),
    .TX_VALID_O(txv), .TX_DATA_O(txd), .TX_READY_I(txr), .TX_LEVEL_O(txl),
    .RX_LEVEL_O(rxl));
  sfw_shifter_model shm (.clk_i(clk), .rst_n_i(rst_n), .send_i(snd),
    .word_i(sw), .rx_valid_o(rxv), .rx_data_o(rxd), .tx_ready_o(txr));
  task chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task results();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task apb(logic w, logic [7:0] a, logic [31:0] d, logic e, sfw_word_t x);
    if (!e && w) txq.push_back(d[15:0]);
    if (!e && !w) rdq.push_back(x);
    @(negedge clk);
    sel = 1;
    wr = w;
    adr = a;
    wd = d;
    @(negedge clk);
    ena = 1;
    repeat (8) begin
      @(posedge clk);
      if (rdy) break;
    end
    chk("ready", 1, rdy);
    chk("err", e, err);
    @(negedge clk);
    sel = 0;
    ena = 0;
  endtask
  always @(posedge clk) begin
    if (rdy && !wr && !err)
      chk("rdata", {16'h0000, rdq.pop_front()}, rd);
    if (txv) chk("txdata", txq.pop_front(), txd);
    cyc++;
    if (cyc > 2000) begin
      errors++;
      results();
    end
  end
  initial begin
    void'($urandom(32'h0675CC80));
    repeat (6) @(negedge clk);
    rst_n = 1;
    en = 1;
    repeat (3) @(negedge clk);
    foreach (al[i]) apb(1, al[i], $urandom(), 0, 0);
    snd = 1;
    foreach (al[i]) begin
      sw = 16'($urandom());
      sent[i] = sw;
      @(negedge clk);
    end
    snd = 0;
    repeat (2) @(negedge clk);
    chk("rxlevel", 6, rxl);
    chk("rxready", 1, rxr);
    foreach (al[i]) apb(0, al[i], 0, 0, sent[i]);
    apb(0, 8'h7C, 0, 0, 0);
    apb(1, 8'h5C, 32'h1234, 1, 0);
    apb(1, 8'hF0, 32'h1234, 1, 0);
    apb(0, 8'h61, 0, 1, 0);
    snd = 1;
    sw = 16'hA5A5;
    @(negedge clk);
    snd = 0;
    repeat (2) @(negedge clk);
    chk("rxlevel", 1, rxl);
    en = 0;
    apb(1, 8'h8C, 32'h0000BEEF, 1, 0);
    repeat (4) @(negedge clk);
    chk("rxlevel", 0, rxl);
    chk("rxready", 0, rxr);
    en = 1;
    repeat (3) @(negedge clk);
    apb(0, 8'h98, 0, 0, 0);
    repeat (20) @(negedge clk);
    chk("rxleft", 0, rdq.size());
    chk("txleft", 0, txq.size());
    chk("txlevel", 0, txl);
    results();
  end
endmodule
`default_nettype wire
